// ### rtl/jtag_link_if.sv
// Test access link between the scan host and the device port
`timescale 1ns/1ns
interface jtag_link_if;
	logic tck;    // Test clock, made by the host
	logic tms;    // Mode select
	logic tdi;    // Serial data toward the device
	logic tdo;    // Serial data from the device
	logic tdo_oe; // Device drives tdo while high
	logic trst_n; // Optional test reset, active low

	// Device end
	modport device (
		input  tck,
		input  tms,
		input  tdi,
		input  trst_n,
		output tdo,
		output tdo_oe
	);

	// Host end
	modport host (
		output tck,
		output tms,
		output tdi,
		output trst_n,
		input  tdo,
		input  tdo_oe
	);
endinterface

// ### rtl/jtag_pkg.sv
// Shared constants, types and helpers for the test access port and its host
package jtag_pkg;

	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int IR_W          = 8;   // Instruction register width
	localparam int ID_W          = 32;  // Identification register width
	localparam int BUF_W         = 128; // Core data buffer width
	localparam int CELLS_PER_IO  = 4;   // Boundary cells per pin
	localparam int CLK_PERIOD_NS = 40;  // System clock period
	localparam int TCK_PERIOD_NS = 320; // Default test clock period
	localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int TLR_CLOCKS    = 5;   // Mode-high clocks for a reset

	// Boundary cell slots within one pin's group of four
	localparam int CELL_IN   = 0; // Pin input observe
	localparam int CELL_OUT  = 1; // Output data control
	localparam int CELL_OE   = 2; // Output enable control
	localparam int CELL_IN2  = 3; // Second input observe

	// ****************************************************************
	// Instruction codes
	// ****************************************************************
	localparam logic [7:0] OP_EXTEST   = 8'h00;
	localparam logic [7:0] OP_SAMPLE   = 8'h01;
	localparam logic [7:0] OP_CLAMP    = 8'h05;
	localparam logic [7:0] OP_HIGHZ    = 8'h07;
	localparam logic [7:0] OP_USERCODE = 8'h0e;
	localparam logic [7:0] OP_IDCODE   = 8'h0f;
	localparam logic [7:0] OP_BYPASS   = 8'hff;
	localparam logic [7:0] USER_LO     = 8'h10;
	localparam logic [7:0] USER_HI     = 8'h7f;
	localparam logic [7:0] PROG_LO     = 8'h80; // Core command range
	localparam logic [7:0] PROG_HI     = 8'hfe;
	localparam logic [7:0] IR_CAPTURE  = 8'h01; // Fixed capture pattern

	// ****************************************************************
	// Host register map (APB byte offsets) and fields
	// ****************************************************************
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_TMS    = 12'h008;
	localparam logic [11:0] REG_TDI    = 12'h00c;
	localparam logic [11:0] REG_TDO    = 12'h010;
	localparam int CTRL_COUNT_MSB = 5;  // Bits to shift, 1..32
	localparam int CTRL_GO_BIT    = 8;  // Start a vector shift
	localparam int CTRL_TLR_BIT   = 9;  // Start a reset sequence
	localparam int CTRL_TRST_BIT  = 10; // Hold test reset pin low
	localparam int STAT_BUSY_BIT  = 0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} tap_state_t;

	typedef enum logic [2:0] {
		DR_BYPASS, DR_ID, DR_USERCODE, DR_BSR, DR_USER, DR_BUFFER
	} dr_sel_t;

	typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} host_phase_t;

	// Controller transition on one rising test clock edge
	function automatic tap_state_t tap_next(tap_state_t s, logic m);
		case (s)
			TLR:     return m ? TLR    : RTI;
			RTI:     return m ? SEL_DR : RTI;
			SEL_DR:  return m ? SEL_IR : CAP_DR;
			CAP_DR:  return m ? EX1_DR : SH_DR;
			SH_DR:   return m ? EX1_DR : SH_DR;
			EX1_DR:  return m ? UPD_DR : PA_DR;
			PA_DR:   return m ? EX2_DR : PA_DR;
			EX2_DR:  return m ? UPD_DR : SH_DR;
			UPD_DR:  return m ? SEL_DR : RTI;
			SEL_IR:  return m ? TLR    : CAP_IR;
			CAP_IR:  return m ? EX1_IR : SH_IR;
			SH_IR:   return m ? EX1_IR : SH_IR;
			EX1_IR:  return m ? UPD_IR : PA_IR;
			PA_IR:   return m ? EX2_IR : PA_IR;
			EX2_IR:  return m ? UPD_IR : SH_IR;
			UPD_IR:  return m ? SEL_DR : RTI;
			default: return TLR;
		endcase
	endfunction

	// Data register chosen by an instruction code
	function automatic dr_sel_t dr_select(logic [7:0] op);
		if (op >= USER_LO && op <= USER_HI)
			return DR_USER;
		if (op >= PROG_LO && op <= PROG_HI)
			return DR_BUFFER;
		case (op)
			OP_EXTEST, OP_SAMPLE: return DR_BSR;
			OP_IDCODE:            return DR_ID;
			OP_USERCODE:          return DR_USERCODE;
			default:              return DR_BYPASS;
		endcase
	endfunction

endpackage

// ### rtl/scan_host.sv
// Scan host: APB registers drive bit vectors onto the test link
`timescale 1ns/1ns
module scan_host
	import jtag_pkg::*;
#(
	parameter int HALF_CYCLES = TCK_HALF_CYCLES // Clock cycles per half
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	jtag_link_if.host        link
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic        tdo_s1;  // Synchroniser first stage
		logic        tdo_s2;  // Synchronised test output
		logic [31:0] tms_vec; // Mode bits, bit 0 first
		logic [31:0] tdi_vec; // Data bits, bit 0 first
		logic [31:0] tdo_vec; // Captured bits, bit 0 first
		logic [5:0]  count;   // Bits per shift
		logic        trst;    // Hold test reset pin
		logic        tlr;     // Reset sequence is the current or last shift
		logic [4:0]  idx;     // Bit in flight
		logic [4:0]  last;    // Final bit of this shift
		logic [7:0]  div;     // Half-period counter
		host_phase_t phase;
		logic        tck;
		logic        tms;
		logic        tdi;
		logic [31:0] prdata;
	} host_state_t;

	host_state_t r;      // Registered state
	host_state_t next_r; // Next state
	logic        busy;   // Shift in progress
	logic        mapped; // Address hits a register

	assign busy   = (r.phase != PH_IDLE);
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_TMS) || (paddr == REG_TDI) || (paddr == REG_TDO);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_r = r;
		next_r.tdo_s1 = link.tdo;
		next_r.tdo_s2 = r.tdo_s1;

		// Read data latched in the setup cycle, zero-wait access
		if (psel && !penable)
			case (paddr)
				REG_CTRL:   next_r.prdata = {21'h000000, r.trst, 4'h0,
					r.count};
				REG_STATUS: next_r.prdata = {31'h00000000, busy};
				REG_TMS:    next_r.prdata = r.tms_vec;
				REG_TDI:    next_r.prdata = r.tdi_vec;
				REG_TDO:    next_r.prdata = r.tdo_vec;
				default:    next_r.prdata = 32'h00000000;
			endcase

		// Bit sequencer: low half, then high half, sample before falling
		if (busy)
		begin
			if (r.div == 8'(HALF_CYCLES - 1))
			begin
				next_r.div = 8'h00;
				if (r.phase == PH_LOW)
				begin
					next_r.tck   = 1'b1;
					next_r.phase = PH_HIGH;
				end
				else
				begin
					next_r.tdo_vec[r.idx] = r.tdo_s2;
					next_r.tck = 1'b0;
					if (r.idx == r.last)
						next_r.phase = PH_IDLE;
					else
					begin
						// Next bit set up while the clock is low
						next_r.idx   = r.idx + 5'h01;
						next_r.tms   = r.tlr | r.tms_vec[r.idx + 5'h01];
						next_r.tdi   = r.tdi_vec[r.idx + 5'h01];
						next_r.phase = PH_LOW;
					end
				end
			end
			else
				next_r.div = r.div + 8'h01;
		end

		// Register writes; vectors and starts are ignored while busy
		if (psel && penable && pwrite)
			case (paddr)
				REG_TMS:
					if (!busy)
						next_r.tms_vec = pwdata;
				REG_TDI:
					if (!busy)
						next_r.tdi_vec = pwdata;
				REG_CTRL:
				begin
					next_r.trst = pwdata[CTRL_TRST_BIT];
					if (!busy)
					begin
						next_r.count = pwdata[CTRL_COUNT_MSB:0];
						if (pwdata[CTRL_TLR_BIT])
						begin
							// Five mode-high clocks reach reset from anywhere
							next_r.tlr   = 1'b1;
							next_r.last  = 5'(TLR_CLOCKS - 1);
							next_r.idx   = 5'h00;
							next_r.div   = 8'h00;
							next_r.tms   = 1'b1;
							next_r.tdi   = 1'b0;
							next_r.phase = PH_LOW;
						end
						else if (pwdata[CTRL_GO_BIT] &&
							pwdata[CTRL_COUNT_MSB:0] != 6'h00)
						begin
							// Host walks full paths from its vectors
							next_r.tlr   = 1'b0;
							next_r.last  = 5'(pwdata[CTRL_COUNT_MSB:0] - 6'h01);
							next_r.idx   = 5'h00;
							next_r.div   = 8'h00;
							next_r.tms   = r.tms_vec[0];
							next_r.tdi   = r.tdi_vec[0];
							next_r.phase = PH_LOW;
						end
					end
				end
				default:
				begin
				end
			endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r       <= '0;
			r.phase <= PH_IDLE;
		end
		else
			r <= next_r;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata      = r.prdata;
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~mapped;
	assign link.tck    = r.tck;
	assign link.tms    = r.tms;
	assign link.tdi    = r.tdi;
	assign link.trst_n = ~r.trst;

endmodule

// ### rtl/scan_tap_device.sv
// Device test access port with boundary scan and user fabric extension
`timescale 1ns/1ns
module scan_tap_device
	import jtag_pkg::*;
#(
	parameter int         NUM_IO    = 4,
	parameter logic [3:0] ID_VER    = 4'h1,     // Arbitrary value
	parameter logic [15:0] ID_PART  = 16'h0001, // Arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h001,  // Arbitrary value
	parameter logic [31:0] USERCODE = 32'h0000_0000
)(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	jtag_link_if.device               link,
	input  wire logic                 device_reset_pin_n,
	// Fabric side of the user scan extension
	output logic [IR_W-1:0]           fabric_instruction_copy,
	output logic                      fabric_test_reset_n,
	output logic                      fabric_scan_in,
	output logic                      fabric_scan_clock,
	input  wire logic                 fabric_scan_return,
	output logic                      fabric_dr_shift_flag,
	output logic                      fabric_dr_capture_flag,
	output logic                      fabric_dr_update_flag,
	// Pins under boundary control
	input  wire logic [NUM_IO-1:0]    pad_in,
	output logic [NUM_IO-1:0]         pad_out,
	output logic [NUM_IO-1:0]         pad_oe,
	input  wire logic [NUM_IO-1:0]    core_pin_out,
	input  wire logic [NUM_IO-1:0]    core_pin_oe,
	// Controller core command path
	output logic [IR_W-1:0]           core_command,
	output logic [BUF_W-1:0]          core_data,
	output logic                      core_data_strobe,
	input  wire logic [BUF_W-1:0]     core_data_in,
	output logic                      programming_active
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam int BSR_W = NUM_IO * CELLS_PER_IO;
	localparam logic [ID_W-1:0] ID_VALUE = {ID_VER, ID_PART, ID_MAKER,
		1'b1};

	typedef struct packed {
		logic              tck_s1;  // Synchroniser first stages
		logic              tms_s1;
		logic              tdi_s1;
		logic              ret_s1;
		logic              tck_s2;  // Synchronised levels
		logic              tms_s2;
		logic              tdi_s2;
		logic              ret_s2;
		logic              tck_d;   // Previous clock level for edges
		tap_state_t        state;   // Controller state
		logic [IR_W-1:0]   ir;      // Active instruction
		logic [IR_W-1:0]   ir_shift; // Instruction shift stage
		logic [IR_W-1:0]   ir_copy; // Copy shown to the fabric
		logic              bypass;  // One-bit bypass stage
		logic [ID_W-1:0]   id_shift; // Identification / usercode
		logic [BSR_W-1:0]  bsr;     // Boundary shift stage
		logic [BSR_W-1:0]  bsr_upd; // Boundary parallel outputs
		logic [BUF_W-1:0]  buffer;  // Core data buffer shift stage
		logic [BUF_W-1:0]  data;    // Data handed to the core
		logic [IR_W-1:0]   command; // Command handed to the core
		logic              strobe;  // New command and data
		logic              tdo;
		logic              tdo_oe;
		logic              rst_n;   // Fabric reset, active low
		logic              shift_f;
		logic              cap_f;
		logic              upd_f;
		logic [NUM_IO-1:0] pad_out;
		logic [NUM_IO-1:0] pad_oe;
	} dev_state_t;

	dev_state_t r;      // Registered state
	dev_state_t next_r; // Next state
	logic       tap_rst_n; // Combined asynchronous reset
	logic       rise;   // Rising test clock seen this cycle
	logic       fall;   // Falling test clock seen this cycle
	dr_sel_t    sel;    // Data register chosen by the instruction
	logic       prog;   // Core command in progress

	// Any of the three resets holds the controller; the pins are
	// asynchronous, so release may land anywhere in a clock cycle
	assign tap_rst_n = presetn & link.trst_n & device_reset_pin_n;

	// Plain wires to the fabric, no logic in the path
	assign fabric_scan_in    = link.tdi;
	assign fabric_scan_clock = link.tck;

	assign rise = r.tck_s2 & ~r.tck_d;
	assign fall = ~r.tck_s2 & r.tck_d;
	assign sel  = dr_select(r.ir);
	assign prog = (sel == DR_BUFFER);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_r = r;
		// Two flip-flops on the clock, mode, data and fabric return inputs
		next_r.tck_s1 = link.tck;
		next_r.tms_s1 = link.tms;
		next_r.tdi_s1 = link.tdi;
		next_r.ret_s1 = fabric_scan_return;
		next_r.tck_s2 = r.tck_s1;
		next_r.tms_s2 = r.tms_s1;
		next_r.tdi_s2 = r.tdi_s1;
		next_r.ret_s2 = r.ret_s1;
		next_r.tck_d  = r.tck_s2;
		next_r.strobe = 1'b0;

		if (rise)
		begin
			// Mode sampled at the edge steers the controller
			next_r.state = tap_next(r.state, r.tms_s2);
			case (r.state)
				TLR:
				begin
					next_r.ir = OP_IDCODE;
				end
				CAP_IR:
				begin
					next_r.ir_shift = IR_CAPTURE;
				end
				SH_IR:
				begin
					// Instruction bits enter here
					next_r.ir_shift = {r.tdi_s2, r.ir_shift[IR_W-1:1]};
				end
				CAP_DR:
				begin
					next_r.bypass = 1'b0;
					if (sel == DR_ID)
						next_r.id_shift = ID_VALUE;
					else if (sel == DR_USERCODE)
						next_r.id_shift = USERCODE;
					else if (sel == DR_BUFFER)
						next_r.buffer = core_data_in;
					else if (sel == DR_BSR)
					begin
						// Parallel-in of every cell
						for (int i = 0; i < NUM_IO; i++)
						begin
							next_r.bsr[i*CELLS_PER_IO+CELL_IN]  = pad_in[i];
							next_r.bsr[i*CELLS_PER_IO+CELL_OUT] = r.pad_out[i];
							next_r.bsr[i*CELLS_PER_IO+CELL_OE]  = r.pad_oe[i];
							next_r.bsr[i*CELLS_PER_IO+CELL_IN2] = pad_in[i];
						end
					end
				end
				SH_DR:
				begin
					// Data bits enter the selected register
					case (sel)
						DR_ID, DR_USERCODE:
							next_r.id_shift = {r.tdi_s2, r.id_shift[ID_W-1:1]};
						DR_BSR:
							next_r.bsr = {r.tdi_s2, r.bsr[BSR_W-1:1]};
						DR_BUFFER:
							next_r.buffer = {r.tdi_s2, r.buffer[BUF_W-1:1]};
						default:
							next_r.bypass = r.tdi_s2;
					endcase
				end
				default:
				begin
				end
			endcase

			// Both change entering update-ir; the instruction also reloads on edges in TLR
			if (next_r.state == UPD_IR)
			begin
				next_r.ir      = r.ir_shift;
				next_r.ir_copy = r.ir_shift;
			end
			if (next_r.state == UPD_DR)
			begin
				if (sel == DR_BSR)
					next_r.bsr_upd = r.bsr;
				if (prog)
				begin
					// Core takes command and data together
					next_r.command = r.ir;
					next_r.data    = r.buffer;
					next_r.strobe  = 1'b1;
				end
			end
		end

		// Test output moves only on the falling clock
		if (fall)
		begin
			next_r.tdo_oe = (r.state == SH_DR) || (r.state == SH_IR);
			if (r.state == SH_IR)
				next_r.tdo = r.ir_shift[0];
			else
				case (sel)
					DR_ID, DR_USERCODE: next_r.tdo = r.id_shift[0];
					DR_BSR:    next_r.tdo = r.bsr[0];
					DR_BUFFER: next_r.tdo = r.buffer[0];
					DR_USER:   next_r.tdo = r.ret_s2;
					default:   next_r.tdo = r.bypass;
				endcase
		end

		// Fabric phase flags follow the state, silent while programming
		next_r.rst_n   = (next_r.state != TLR);
		next_r.shift_f = (next_r.state == SH_DR) & ~prog;
		next_r.cap_f   = (next_r.state == CAP_DR) & ~prog;
		next_r.upd_f   = (next_r.state == UPD_DR) & ~prog;

		// Pin control: boundary cells in extest and clamp, off in highz
		for (int i = 0; i < NUM_IO; i++)
		begin
			if (r.ir == OP_HIGHZ)
			begin
				next_r.pad_out[i] = 1'b0;
				next_r.pad_oe[i]  = 1'b0;
			end
			else if (r.ir == OP_EXTEST || r.ir == OP_CLAMP)
			begin
				next_r.pad_out[i] = r.bsr_upd[i*CELLS_PER_IO+CELL_OUT];
				next_r.pad_oe[i]  = r.bsr_upd[i*CELLS_PER_IO+CELL_OE];
			end
			else
			begin
				next_r.pad_out[i] = core_pin_out[i];
				next_r.pad_oe[i]  = core_pin_oe[i];
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge tap_rst_n)
	begin
		if (!tap_rst_n)
		begin
			r       <= '0;
			r.state <= TLR;
			r.ir    <= OP_IDCODE;
			r.ir_copy <= OP_IDCODE;
		end
		else
			r <= next_r;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign link.tdo               = r.tdo;
	assign link.tdo_oe            = r.tdo_oe;
	assign fabric_instruction_copy = r.ir_copy;
	assign fabric_test_reset_n    = r.rst_n;
	assign fabric_dr_shift_flag   = r.shift_f;
	assign fabric_dr_capture_flag = r.cap_f;
	assign fabric_dr_update_flag  = r.upd_f;
	assign pad_out                = r.pad_out;
	assign pad_oe                 = r.pad_oe;
	assign core_command           = r.command;
	assign core_data              = r.data;
	assign core_data_strobe       = r.strobe;
	assign programming_active     = prog;

endmodule

// ### sim/scan_link_sva.sv
// Checker of link and fabric flag timing for the scan port
`timescale 1ns/1ns
module scan_link_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       tck,
	input wire logic       tdi,
	input wire logic       tdo,
	input wire logic       tdo_oe,
	input wire logic       trst_n,
	input wire logic       device_reset_pin_n,
	input wire logic [7:0] fabric_instruction_copy,
	input wire logic       fabric_test_reset_n,
	input wire logic       fabric_scan_in,
	input wire logic       fabric_scan_clock,
	input wire logic       fabric_dr_shift_flag,
	input wire logic       fabric_dr_capture_flag,
	input wire logic       fabric_dr_update_flag,
	input wire logic       programming_active
);
	// ****
	// Timing rules
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The capture and update flags each stand one test clock period, eight system clocks
	sequence s_cap_len;
		fabric_dr_capture_flag [*8] ##1 !fabric_dr_capture_flag;
	endsequence
	sequence s_upd_len;
		fabric_dr_update_flag [*8] ##1 !fabric_dr_update_flag;
	endsequence
	a_in_copy: assert property (fabric_scan_in == tdi)
		else $error("Fabric scan input differs");
	a_clk_copy: assert property (fabric_scan_clock == tck)
		else $error("Fabric scan clock differs");
	a_flags_onehot: assert property (
		$onehot0({fabric_dr_shift_flag, fabric_dr_capture_flag,
		fabric_dr_update_flag}))
		else $error("Two phase flags high");
	a_cap_len: assert property ($rose(fabric_dr_capture_flag)
		|-> s_cap_len)
		else $error("Capture flag length wrong");
	a_upd_len: assert property ($rose(fabric_dr_update_flag)
		|-> s_upd_len)
		else $error("Update flag length wrong");
	a_tdo_fall: assert property (
		$changed({tdo, tdo_oe}) |-> !tck)
		else $error("Test output moved while clock high");
	a_copy_edge: assert property (
		$changed(fabric_instruction_copy) && trst_n && device_reset_pin_n
		|-> tck && !fabric_dr_update_flag)
		else $error("Instruction copy moved off update");
	a_pin_reset: assert property (
		!trst_n || !device_reset_pin_n |-> ##1 !fabric_test_reset_n)
		else $error("Reset pin did not reset controller");
	a_flags_reset: assert property (!fabric_test_reset_n |->
		!(fabric_dr_shift_flag || fabric_dr_capture_flag))
		else $error("Flag high in reset state");
	// Core commands own the scan path, so the fabric must see no phase
	a_prog_quiet: assert property (programming_active |->
		!(fabric_dr_shift_flag || fabric_dr_capture_flag ||
		fabric_dr_update_flag))
		else $error("Phase flag high while programming");
endmodule

// ### sim/tb.sv
// Testbench joining scan host and device port over the link
`timescale 1ns/1ns
module tb;
	import jtag_pkg::*;
	localparam logic [10:0] MAKER = 11'h2a5;      // Arbitrary value
	localparam logic [31:0] UCODE = 32'h0000_003c; // Arbitrary value
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'hb3c15674;
	logic        pready, pslverr, err, device_reset_pin_n = 1;
	logic        fabric_scan_return, programming_active;
	logic [3:0]  pad_in, core_pin_out, core_pin_oe, pad_oe;
	logic [7:0]  core_command; // Last command handed to the core
	logic [7:0]  fabric_instruction_copy, m, ops[$] = '{OP_BYPASS, OP_CLAMP,
		OP_HIGHZ, OP_IDCODE, OP_USERCODE, OP_EXTEST, OP_SAMPLE, PROG_LO,
		USER_LO, USER_HI};
	logic        fabric_test_reset_n, fabric_scan_in, fabric_scan_clock;
	logic        fabric_dr_shift_flag, fabric_dr_capture_flag;
	logic        fabric_dr_update_flag;
	int          bad_count = 0, comparisons = 0, cyc = 0;
	// Pin inputs follow the random word so every loop pass sees fresh values
	assign {pad_in, core_pin_out, core_pin_oe} = seed[11:0];
	// Fabric debug mux: the instruction copy picks one net of the random word
	assign fabric_scan_return = seed[fabric_instruction_copy[4:0]];
	jtag_link_if link();
	scan_host i_scan_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .link);
	scan_tap_device #(.ID_MAKER(MAKER), .USERCODE(UCODE)) i_scan_tap_device (
		.pclk, .presetn, .link, .device_reset_pin_n, .fabric_instruction_copy,
		.fabric_test_reset_n, .fabric_scan_in, .fabric_scan_clock,
		.fabric_scan_return, .fabric_dr_shift_flag, .fabric_dr_capture_flag,
		.fabric_dr_update_flag, .pad_in, .pad_out(), .pad_oe, .core_pin_out,
		.core_pin_oe, .core_command, .core_data(), .core_data_strobe(),
		.core_data_in({4{seed}}), .programming_active);
	scan_link_sva i_sva (.pclk, .presetn, .tck(link.tck), .tdi(link.tdi),
		.tdo(link.tdo), .tdo_oe(link.tdo_oe), .trst_n(link.trst_n),
		.device_reset_pin_n, .fabric_instruction_copy, .fabric_test_reset_n,
		.fabric_scan_in, .fabric_scan_clock, .fabric_dr_shift_flag,
		.fabric_dr_capture_flag, .fabric_dr_update_flag, .programming_active);
	// ****
	// Clock, timeout and helpers
	// ****
	always #20 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			give_verdict;
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected data register byte for an instruction, from the rules
	function automatic logic [7:0] exp_dr(input logic [7:0] op, r);
		if (op >= USER_LO && op <= USER_HI)
			return {8{fabric_scan_return}};
		// Core codes capture the core's data word into the buffer
		if (op >= PROG_LO && op <= PROG_HI)
			return r;
		case (op)
			OP_IDCODE:            return {MAKER[6:0], 1'b1};
			OP_USERCODE:          return UCODE[7:0];
			OP_EXTEST, OP_SAMPLE: return {3'b0, pad_in[1], 3'b0, pad_in[0]};
			default:              return {r[6:0], 1'b0};
		endcase
	endfunction
	task chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; waits for pready, result left in rd and err
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Shift n link bits, LSB first, and read back the sampled output
	task shift(input logic [31:0] t, d, input int n);
		apb(1, REG_TMS, t);
		apb(1, REG_TDI, d);
		apb(1, REG_CTRL, (1 << CTRL_GO_BIT) | n);
		do apb(0, REG_STATUS, 0); while (rd[STAT_BUSY_BIT] !== 1'b0);
		apb(0, REG_TDO, 0);
	endtask
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		chk(fabric_test_reset_n, 0);
		ops.push_back(8'(USER_LO + seed[6:0] % 112));
		apb(0, 12'h0fc, 0);
		chk(err, 1);
		foreach (ops[i])
		begin
			// Random word moves like any input, off the sampling instant
			seed <= lfsr(seed);
			// Instruction load through the full instruction path
			shift(32'h3006, 32'(ops[i]) << 5, 15);
			chk((rd >> 5) & 8'hff, IR_CAPTURE);
			chk(fabric_instruction_copy,
				ops[i]);
			chk(fabric_test_reset_n, 1);
			if (ops[i] == OP_HIGHZ)
				chk(pad_oe, 0);
			// Eight bit data scan; boundary cells masked to the CELL_IN cells of pins 0 and 1
			shift(32'h0c01, seed << 3, 13);
			m = (ops[i] == OP_EXTEST || ops[i] == OP_SAMPLE) ? 8'h11 : 8'hff;
			chk((rd >> 3) & m,
				exp_dr(ops[i], seed) & m);
		end
		// Park in pause-dr, then the host's own reset sequence
		shift(32'h5, 0, 4);
		apb(1, REG_CTRL, 1 << CTRL_TLR_BIT);
		do apb(0, REG_STATUS, 0); while (rd[STAT_BUSY_BIT] !== 1'b0);
		chk(fabric_test_reset_n, 0);
		chk(fabric_instruction_copy, ops[ops.size()-1]);
		chk(core_command, PROG_LO);
		shift(0, 0, 1);
		apb(1, REG_CTRL, 1 << CTRL_TRST_BIT);
		repeat (2) @(posedge pclk);
		chk(fabric_test_reset_n, 0);
		apb(1, REG_CTRL, 0);
		shift(0, 0, 1);
		device_reset_pin_n <= 0;
		repeat (2) @(posedge pclk);
		chk(fabric_test_reset_n, 0);
		device_reset_pin_n <= 1;
		give_verdict;
	end
endmodule
